// ### dsc_regs.svh
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_OFF_CONFIG 8'h00
`define DSC_OFF_DAC 8'h04
`define DSC_OFF_RESULT_A 8'h08
`define DSC_OFF_RESULT_B 8'h0c
`define DSC_OFF_STATUS 8'h10
`define DSC_CFG_RST 12'h000
`define DSC_DAC_RST 10'h3ff
`define DSC_CFG_SEL_HI 11
`define DSC_CFG_SEL_LO 10
`define DSC_CFG_UPD_HI 9
`define DSC_CFG_UPD_LO 8
`define DSC_CFG_REFPD 4
`define DSC_CFG_ACT_HI 2
`define DSC_CFG_ACT_LO 0
`define DSC_UPD_ENABLE 2'h1
`define DSC_ACT_DAC_WR 3'h1
`define DSC_CONV_LAST 4'hb
`define DSC_RESULT_ZERO 12'h000
`define DSC_STAT_BUSY 0
`define DSC_STAT_VALID_A 1
`define DSC_STAT_VALID_B 2
`define DSC_STAT_DAC_NEXT 3
`endif

// ### dsc_pkg.sv
package dsc_pkg;
	typedef enum {ST_ACQ, ST_HOLD, ST_CONV, ST_PRECH} dsc_state_t;
	typedef enum logic [1:0] {
		POS_PAIR0 = 2'h0,
		POS_PAIR1_NEG = 2'h1,
		POS_PAIR1 = 2'h2
	} dsc_pos_sel_t;
	typedef enum logic {
		NEG_PAIR0 = 1'h0,
		NEG_PAIR1 = 1'h1
	} dsc_neg_sel_t;
endpackage

// ### dsc_sar_if.sv
`timescale 1ns/1ps
interface dsc_sar_if #(
	parameter int W = 12
);
	logic start;
	logic step;
	logic cmp;
	logic [W-1:0] trial;
	logic [W-1:0] result;
	modport ctrl(output start, output step, output cmp, input trial, input result);
	modport sar(input start, input step, input cmp, output trial, output result);
endinterface

// ### dsc_sar.sv
`timescale 1ns/1ps
module dsc_sar #(
	parameter int W = 12
) (
	input wire logic clk,
	input wire logic arst_n,
	dsc_sar_if.sar bus
);
	localparam int IW = $clog2(W);
	localparam logic [IW-1:0] TOP = IW'(W - 1);
	localparam logic [W-1:0] MID = {1'b1, {(W-1){1'b0}}};

	logic [W-1:0] trial_q;
	logic [IW-1:0] bitIdx_q;
	logic [W-1:0] result_q;
	logic [W-1:0] final_w;

	assign bus.trial = trial_q;
	assign bus.result = result_q;

	always_comb begin
		final_w = trial_q;
		final_w[bitIdx_q] = bus.cmp;
	end

	// one bit decided per conversion-clock rise, msb first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trial_q <= '0;
			bitIdx_q <= '0;
		end else if (bus.start) begin
			trial_q <= MID;
			bitIdx_q <= TOP;
		end else if (bus.step) begin
			trial_q <= final_w;
			if (bitIdx_q != '0) begin
				trial_q[bitIdx_q - 1'b1] <= 1'b1;
				bitIdx_q <= bitIdx_q - 1'b1;
			end
		end
	end

	// offset binary from the array turned to twos complement by inverting the msb
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result_q <= '0;
		end else if (bus.step && bitIdx_q == '0) begin
			result_q <= {~final_w[W-1], final_w[W-2:0]};
		end
	end
endmodule

// ### dsc_conv_ctrl.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "dsc_regs.svh"
module dsc_conv_ctrl #(
	parameter int W = 12,
	parameter int DAC_W = 10
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic convClk,
	input wire logic conversion_start_n,
	input wire logic [1:0] cmpBit,
	input wire logic [7:0] regAddr,
	input wire logic [11:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output logic busy,
	output logic sampleSwitch,
	output logic precharge,
	output logic [1:0] muxPosSel,
	output logic muxNegSel,
	output wire logic [1:0][W-1:0] sarTrial,
	output logic [DAC_W-1:0] refDacCode,
	output logic refEnable
);
	dsc_pkg::dsc_state_t state_q;
	logic convClkPrev_q;
	logic convStPrev_q;
	logic clkRise;
	logic convStFall;
	logic [3:0] bitCnt_q;
	logic [11:0] config_q;
	logic [DAC_W-1:0] dac_q;
	logic dacNext_q;
	logic [1:0][W-1:0] result_q;
	logic [1:0] valid_q;
	logic [1:0] rdResult;
	logic [1:0] loadResult;
	logic cfgWr;
	logic dacWr;
	logic [1:0] selCode;

	dsc_sar_if #(.W(W)) sarBus[2] ();

	// conversion clock and start are sampled as ordinary synchronous inputs
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			convClkPrev_q <= 1'b0;
			convStPrev_q <= 1'b1;
		end else begin
			convClkPrev_q <= convClk;
			convStPrev_q <= conversion_start_n;
		end
	end

	assign clkRise = convClk & ~convClkPrev_q;
	assign convStFall = convStPrev_q & ~conversion_start_n;

	// both converters share start and step so they sample and convert together
	generate
		for (genvar g = 0; g < 2; g++) begin : g_conv
			assign sarBus[g].start = (state_q == dsc_pkg::ST_HOLD) && clkRise;
			assign sarBus[g].step = (state_q == dsc_pkg::ST_CONV) && clkRise;
			assign sarBus[g].cmp = cmpBit[g];
			assign sarTrial[g] = sarBus[g].trial;
			assign loadResult[g] = (state_q == dsc_pkg::ST_PRECH) && clkRise;
			dsc_sar #(.W(W)) u_sar (
				.clk(ref_clk),
				.arst_n(arst_n),
				.bus(sarBus[g])
			);

			// a fresh result wins over a read clearing the old one
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					result_q[g] <= '0;
					valid_q[g] <= 1'b0;
				end else if (loadResult[g]) begin
					result_q[g] <= sarBus[g].result;
					valid_q[g] <= 1'b1;
				end else if (rdResult[g]) begin
					valid_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// conversion sequence: leaves acquisition on the start fall, then one step per conversion-clock rise
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= dsc_pkg::ST_ACQ;
			bitCnt_q <= '0;
		end else begin
			unique case (state_q)
				dsc_pkg::ST_ACQ: begin
					// starts during busy never reach here, so they are simply ignored
					if (convStFall) begin
						state_q <= dsc_pkg::ST_HOLD;
					end
				end
				dsc_pkg::ST_HOLD: begin
					if (clkRise) begin
						state_q <= dsc_pkg::ST_CONV;
						bitCnt_q <= '0;
					end
				end
				dsc_pkg::ST_CONV: begin
					if (clkRise) begin
						bitCnt_q <= bitCnt_q + 4'h1;
						if (bitCnt_q == `DSC_CONV_LAST) begin
							state_q <= dsc_pkg::ST_PRECH;
						end
					end
				end
				dsc_pkg::ST_PRECH: begin
					if (clkRise) begin
						state_q <= dsc_pkg::ST_ACQ;
					end
				end
			endcase
		end
	end

	// analog controls registered so the pins never glitch
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			sampleSwitch <= 1'b1;
			precharge <= 1'b0;
		end else begin
			if ((state_q == dsc_pkg::ST_HOLD) && clkRise) begin
				busy <= 1'b1;
			end else if ((state_q == dsc_pkg::ST_PRECH) && clkRise) begin
				busy <= 1'b0;
			end
			if ((state_q == dsc_pkg::ST_ACQ) && convStFall) begin
				sampleSwitch <= 1'b0;
			end else if ((state_q == dsc_pkg::ST_PRECH) && clkRise) begin
				sampleSwitch <= 1'b1;
			end
			if ((state_q == dsc_pkg::ST_CONV) && clkRise && bitCnt_q == `DSC_CONV_LAST) begin
				precharge <= 1'b1;
			end else if ((state_q == dsc_pkg::ST_PRECH) && clkRise) begin
				precharge <= 1'b0;
			end
		end
	end

	// a configuration write asking for a dac write diverts the next config write to the dac
	assign cfgWr = regWr && regAddr == `DSC_OFF_CONFIG && !dacNext_q;
	assign dacWr = regWr && (regAddr == `DSC_OFF_DAC ||
		(regAddr == `DSC_OFF_CONFIG && dacNext_q));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			config_q <= `DSC_CFG_RST;
			dacNext_q <= 1'b0;
		end else if (cfgWr) begin
			config_q <= regWrData;
			dacNext_q <= regWrData[`DSC_CFG_UPD_HI:`DSC_CFG_UPD_LO] == `DSC_UPD_ENABLE &&
				regWrData[`DSC_CFG_ACT_HI:`DSC_CFG_ACT_LO] == `DSC_ACT_DAC_WR;
		end else if (dacWr) begin
			dacNext_q <= 1'b0;
		end
	end

	// low codes are not blocked; keeping them out is the host's job
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dac_q <= `DSC_DAC_RST;
		end else if (dacWr) begin
			dac_q <= regWrData[DAC_W-1:0];
		end
	end

	assign selCode = {config_q[`DSC_CFG_SEL_HI], config_q[`DSC_CFG_SEL_LO]};

	// mux follows the select code at once; the held sample keeps the old channel
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			muxPosSel <= dsc_pkg::POS_PAIR0;
			muxNegSel <= dsc_pkg::NEG_PAIR0;
			refDacCode <= `DSC_DAC_RST;
			refEnable <= 1'b1;
		end else begin
			unique case (selCode)
				2'h0: begin
					muxPosSel <= dsc_pkg::POS_PAIR0;
					muxNegSel <= dsc_pkg::NEG_PAIR0;
				end
				2'h1: begin
					muxPosSel <= dsc_pkg::POS_PAIR1_NEG;
					muxNegSel <= dsc_pkg::NEG_PAIR0;
				end
				2'h2: begin
					muxPosSel <= dsc_pkg::POS_PAIR1;
					muxNegSel <= dsc_pkg::NEG_PAIR0;
				end
				2'h3: begin
					muxPosSel <= dsc_pkg::POS_PAIR1;
					muxNegSel <= dsc_pkg::NEG_PAIR1;
				end
			endcase
			refDacCode <= dac_q;
			refEnable <= ~config_q[`DSC_CFG_REFPD];
		end
	end

	assign rdResult[0] = regRd && regAddr == `DSC_OFF_RESULT_A;
	assign rdResult[1] = regRd && regAddr == `DSC_OFF_RESULT_B;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				`DSC_OFF_CONFIG: regRdData <= 32'(config_q);
				`DSC_OFF_DAC: regRdData <= 32'(dac_q);
				`DSC_OFF_RESULT_A: regRdData <= 32'(valid_q[0] ? result_q[0] : `DSC_RESULT_ZERO);
				`DSC_OFF_RESULT_B: regRdData <= 32'(valid_q[1] ? result_q[1] : `DSC_RESULT_ZERO);
				`DSC_OFF_STATUS: begin
					regRdData <= '0;
					regRdData[`DSC_STAT_BUSY] <= busy;
					regRdData[`DSC_STAT_VALID_A] <= valid_q[0];
					regRdData[`DSC_STAT_VALID_B] <= valid_q[1];
					regRdData[`DSC_STAT_DAC_NEXT] <= dacNext_q;
				end
				default: regRdData <= '0;
			endcase
		end else begin
			regRdData <= '0;
		end
	end
endmodule

// ### dsc_conv_ctrl_monitor.sv
`timescale 1ns/1ps
module dsc_conv_ctrl_monitor #(
	parameter int W = 12,
	parameter int DAC_W = 10
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic conversion_start_n,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic busy,
	input wire logic sampleSwitch,
	input wire logic precharge,
	input wire logic [1:0] muxPosSel,
	input wire logic muxNegSel,
	input wire logic [1:0][W-1:0] sarTrial,
	input wire logic [DAC_W-1:0] refDacCode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	prech_in_busy_a: assert property (precharge |-> busy)
		else $error("precharge outside busy");
	prech_end_a: assert property ($fell(precharge) |-> $fell(busy) && sampleSwitch)
		else $error("precharge end without acquisition");
	prech_before_idle_a: assert property ($fell(busy) |-> $past(precharge))
		else $error("busy fell without precharge");
	switch_open_a: assert property (busy |-> !sampleSwitch)
		else $error("switches closed while busy");
	trial_start_a: assert property ($rose(busy) |-> sarTrial == {2{12'h800}})
		else $error("first trial not midscale");
	hold_start_a: assert property ($fell(conversion_start_n) && !busy && sampleSwitch
		|-> ##[1:3] !sampleSwitch)
		else $error("inputs not held after start");
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside read slot");
	mux_code_a: assert property (muxPosSel != 2'h3)
		else $error("illegal positive select");
	mux_pair_a: assert property (muxNegSel |-> muxPosSel == 2'h2)
		else $error("pair one negative without pair one positive");
	dac_reset_a: assert property ($rose(arst_n) |-> refDacCode == 10'h3ff)
		else $error("dac code not full scale after reset");
endmodule
bind dsc_conv_ctrl dsc_conv_ctrl_monitor #(.W(W), .DAC_W(DAC_W)) dsc_conv_ctrl_monitor_inst (.*);

// ### dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic busy,
	output logic convClk,
	output logic conversion_start_n,
	output logic done
);
	logic [6:0] phase_q;
	initial begin
		phase_q = 7'h0;
		convClk = 1'b0;
		conversion_start_n = 1'b1;
		done = 1'b0;
	end
	// clock only inside a frame, 4 ref_clk per period, parked low after 16 falls
	always @(posedge ref_clk) begin
		done <= 1'b0;
		if (phase_q == 7'h0) begin
			if (go && !busy) begin
				conversion_start_n <= 1'b0;
				phase_q <= 7'h1;
			end
		end else begin
			phase_q <= (phase_q == 7'h44) ? 7'h0 : phase_q + 7'h1;
			done <= (phase_q == 7'h44);
			if (phase_q == 7'h3) begin
				conversion_start_n <= 1'b1;
			end
			convClk <= (phase_q >= 7'h4) && (phase_q < 7'h44) && phase_q[1];
		end
	end
endmodule

// ### dsc_conv_ctrl_bench.sv
`timescale 1ns/1ps
module dsc_conv_ctrl_bench;
	logic ref_clk, arst_n, go, done, convClk, conversion_start_n;
	logic [1:0] cmpBit;
	logic [7:0] regAddr;
	logic [11:0] regWrData;
	logic regWr, regRd, busy, sampleSwitch, precharge, muxNegSel, refEnable;
	logic [31:0] regRdData;
	logic [1:0] muxPosSel;
	logic [1:0][11:0] sarTrial;
	logic [9:0] refDacCode, dac;
	logic [11:0] tA, tB;
	int seed = 32'h058f;
	int n_fail = 0;
	int checked = 0;
	int nb;
	int np;
	dsc_conv_ctrl dsc_conv_ctrl_inst (.*);
	dsc_host_model dsc_host_model_inst (.ref_clk(ref_clk), .go(go), .busy(busy),
		.convClk(convClk), .conversion_start_n(conversion_start_n), .done(done));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// comparator: keep the trial bit while the trial does not exceed the target
	always @(posedge ref_clk) begin
		cmpBit <= {sarTrial[1] <= tB, sarTrial[0] <= tA};
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [11:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
		chk(regRdData, exp);
	endtask
	task automatic conv();
		tA = 12'($random(seed));
		tB = 12'($random(seed));
		nb = 0;
		np = 0;
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		for (int i = 0; i < 200 && !done; i++) begin
			@(posedge ref_clk);
			nb += int'(busy);
			np += int'(precharge);
		end
		if (!done) begin
			n_fail++;
			end_sim();
		end
		chk(nb, 52);
		// the host runs its conversion clock at four system clocks per period
		chk(np, 4);
		rd(8'h10, 32'h6);
		rd(8'h08, {20'h0, tA ^ 12'h800});
		rd(8'h0c, {20'h0, tB ^ 12'h800});
		rd(8'h08, 32'h0);
		rd(8'h10, 32'h0);
	endtask
	initial begin
		arst_n = 1'b0;
		go = 1'b0;
		cmpBit = 2'h0;
		regAddr = 8'h0;
		regWrData = 12'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		tA = 12'h0;
		tB = 12'h0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		chk({busy, sampleSwitch, refEnable, refDacCode}, {3'h3, 10'h3ff});
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h3ff);
		rd(8'h20, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, {c[1:0], 10'h0});
			repeat (2) @(posedge ref_clk);
			chk({muxPosSel, muxNegSel}, {(c == 3) ? 2'h2 : c[1:0], c == 3});
			rd(8'h00, {20'h0, c[1:0], 10'h0});
			conv();
		end
		wr(8'h00, 12'h010);
		repeat (2) @(posedge ref_clk);
		chk(refEnable, 1'b0);
		// codes under 205 would starve the reference buffer, so stay above
		dac = 10'(205 + $unsigned($random(seed)) % 819);
		wr(8'h00, 12'h101);
		rd(8'h10, 32'h8);
		wr(8'h00, {2'h0, dac});
		repeat (2) @(posedge ref_clk);
		chk({refEnable, refDacCode}, {1'b1, dac});
		rd(8'h04, {22'h0, dac});
		wr(8'h04, 12'h3ff);
		rd(8'h04, 32'h3ff);
		end_sim();
	end
endmodule
